// ### core/osd_dispmem_dev.sv
// Purpose: display-memory access logic of the overlay generator
// Assumes: host end holds each request until ack
// Notes:   display memory is flip-flops, word = {char_code_byte, attribute}
`timescale 1ns/100ps
`default_nettype none
module osd_dispmem_dev
  import osd_pkg::*;
(
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_in,
  osd_link_if.device                  link,
  output logic                        overlay_on_out,
  output logic                        fetch_valid_out,
  output logic                        fetch_dropped_out,
  output logic [osd_pkg::LOC_W-1:0]   fetch_loc_out,
  output logic [7:0]                  fetch_char_out,
  output logic [7:0]                  fetch_attr_out
);
  import osd_pkg::*;

  typedef struct packed {
    logic [MEM_DEPTH-1:0][15:0] mem;
    logic [7:0]                 mode;
    logic [7:0]                 addr_high;
    logic [7:0]                 addr_low;
    logic [7:0]                 video_ctl;
    logic                       ai_active;
    logic                       ack;
    logic [15:0]                rdata;
    logic [7:0]                 fetch_cnt;
    logic [LOC_W-1:0]           fetch_loc;
    logic [LOC_W-1:0]           fetch_loc_out;
    logic                       fetch_valid;
    logic                       fetch_drop;
    logic [7:0]                 fetch_char;
    logic [7:0]                 fetch_attr;
  } dev_state_t;

  dev_state_t q;
  dev_state_t d;

  ////////////////////////////////////////////////////////////////////////
  // attribute layouts

  function automatic logic [7:0] attr_from_mode(input logic [7:0] m);
    logic [7:0] a;
    a = 8'h00;
    a[ATTR_WR_LBC] = m[MODE_LBC_BIT];
    a[ATTR_WR_BLK] = m[MODE_BLK_BIT];
    a[ATTR_WR_INV] = m[MODE_INV_BIT];
    return a;
  endfunction

  function automatic logic [7:0] attr_read_view(input logic [7:0] s);
    logic [7:0] a;
    a = 8'h00;
    a[ATTR_RD_LBC] = s[ATTR_WR_LBC];
    a[ATTR_RD_BLK] = s[ATTR_WR_BLK];
    a[ATTR_RD_INV] = s[ATTR_WR_INV];
    return a;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  logic             take;
  logic             host_mem;
  logic             width8;
  logic [LOC_W-1:0] loc;
  logic [15:0]      word;

  always_comb begin
    d                 = q;
    d.ack             = 1'b0;
    d.fetch_valid     = 1'b0;
    d.fetch_drop      = 1'b0;
    take              = link.req_valid && !q.ack;
    width8            = q.mode[MODE_WIDTH8_BIT];
    loc               = {q.addr_high[ADDRH_MSB_BIT], q.addr_low};
    word              = q.mem[loc];
    host_mem          = take && (link.req_reg == REG_DATA_IN ||
                                 link.req_reg == REG_DATA_OUT);

    if (take) begin
      d.ack = 1'b1;
      if (link.req_write) begin
        case (link.req_reg)
          REG_MODE: begin
            d.mode      = link.req_wdata;
            d.ai_active = link.req_wdata[MODE_AUTOINC_BIT];
          end
          REG_ADDR_HIGH: begin
            d.addr_high = link.req_wdata & ADDRH_MASK;
          end
          REG_ADDR_LOW: begin
            d.addr_low  = link.req_wdata;
          end
          REG_VIDEO_CTL: begin
            d.video_ctl = link.req_wdata;
          end
          REG_DATA_IN: begin
            if (q.ai_active && link.req_wdata == TERM_CODE) begin
              d.ai_active              = 1'b0;
              d.mode[MODE_AUTOINC_BIT] = 1'b0;
            end else begin
              if (width8) begin
                if (q.addr_high[ADDRH_BYTESEL_BIT]) begin
                  d.mem[loc][7:0]  = link.req_wdata;
                end else begin
                  d.mem[loc][15:8] = link.req_wdata;
                end
              end else begin
                // one write fills both bytes of the location
                d.mem[loc] = {link.req_wdata, attr_from_mode(q.mode)};
              end
              if (q.ai_active) begin
                {d.addr_high[ADDRH_MSB_BIT], d.addr_low} =
                  LOC_W'(loc + LOC_W'(1));
              end
            end
          end
          default: begin
          end
        endcase
      end else begin
        case (link.req_reg)
          REG_MODE:      d.rdata = {8'h00, q.mode};
          REG_ADDR_HIGH: d.rdata = {8'h00, q.addr_high};
          REG_ADDR_LOW:  d.rdata = {8'h00, q.addr_low};
          REG_VIDEO_CTL: d.rdata = {8'h00, q.video_ctl};
          REG_DATA_OUT: begin
            if (width8) begin
              d.rdata = {8'h00, q.addr_high[ADDRH_BYTESEL_BIT] ?
                                word[7:0] : word[15:8]};
            end else begin
              d.rdata = {word[15:8], attr_read_view(word[7:0])};
            end
          end
          default:       d.rdata = 16'h0000;
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////////
    // internal display fetch, one location per period
    if (q.fetch_cnt == FETCH_PERIOD - 8'h01) begin
      d.fetch_cnt     = 8'h00;
      d.fetch_loc     = LOC_W'(q.fetch_loc + LOC_W'(1));
      d.fetch_loc_out = q.fetch_loc;
      // the slot is lost, that character may glitch for one field
      if (host_mem) begin
        d.fetch_drop  = 1'b1;
      end else begin
        d.fetch_valid = 1'b1;
        d.fetch_char  = q.mem[q.fetch_loc][15:8];
        d.fetch_attr  = q.mem[q.fetch_loc][7:0];
      end
    end else begin
      d.fetch_cnt = q.fetch_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q               <= '0;
      q.mode          <= MODE_RESET;
      q.video_ctl     <= VC0_RESET;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.ack          = q.ack;
  assign link.rdata        = q.rdata;
  assign overlay_on_out    = q.video_ctl[VC0_SHOW_BIT];
  assign fetch_valid_out   = q.fetch_valid;
  assign fetch_dropped_out = q.fetch_drop;
  assign fetch_loc_out     = q.fetch_loc_out;
  assign fetch_char_out    = q.fetch_char;
  assign fetch_attr_out    = q.fetch_attr;
endmodule
`default_nettype wire

// ### core/osd_pkg.sv
// Purpose: shared constants for the display-memory access link and its two ends
// Assumes: one clock domain, synchronous active-high reset
// Notes:   register indices travel on the link, host registers sit behind AXI4-Lite
package osd_pkg;
  // device register indices on the link
  localparam logic [2:0]  REG_MODE      = 3'h0;
  localparam logic [2:0]  REG_ADDR_HIGH = 3'h1;
  localparam logic [2:0]  REG_ADDR_LOW  = 3'h2;
  localparam logic [2:0]  REG_DATA_IN   = 3'h3;
  localparam logic [2:0]  REG_DATA_OUT  = 3'h4;
  localparam logic [2:0]  REG_VIDEO_CTL = 3'h5;
  // mode register fields
  localparam int          MODE_AUTOINC_BIT = 0;
  localparam int          MODE_INV_BIT     = 3;
  localparam int          MODE_BLK_BIT     = 4;
  localparam int          MODE_LBC_BIT     = 5;
  localparam int          MODE_WIDTH8_BIT  = 6;
  localparam logic [7:0]  MODE_RESET       = 8'h00;
  // address-high fields
  localparam int          ADDRH_MSB_BIT    = 0;
  localparam int          ADDRH_BYTESEL_BIT = 1;
  localparam logic [7:0]  ADDRH_MASK       = 8'h03;
  // video control register 0
  localparam int          VC0_SHOW_BIT     = 3;
  localparam logic [7:0]  VC0_RESET        = 8'h00;
  // stored attribute byte layout (write side)
  localparam int          ATTR_WR_LBC      = 7;
  localparam int          ATTR_WR_BLK      = 6;
  localparam int          ATTR_WR_INV      = 5;
  // attribute layout as returned by a 16-bit read
  localparam int          ATTR_RD_LBC      = 4;
  localparam int          ATTR_RD_BLK      = 3;
  localparam int          ATTR_RD_INV      = 2;
  localparam logic [7:0]  TERM_CODE        = 8'hff;
  localparam int          LOC_W            = 9;
  localparam int          MEM_DEPTH        = 512;
  // internal display fetch spacing in clock cycles
  localparam logic [7:0]  FETCH_PERIOD     = 8'h08;
  // host AXI4-Lite register byte offsets
  localparam logic [3:0]  AXI_CMD_OFS      = 4'h0;
  localparam logic [3:0]  AXI_STAT_OFS     = 4'h4;
  localparam logic [3:0]  AXI_RDATA_OFS    = 4'h8;
  // command register fields
  localparam int          CMD_DATA_LO      = 0;
  localparam int          CMD_REG_LO       = 8;
  localparam int          CMD_WRITE_BIT    = 16;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage

// ### core/osd_link_if.sv
// Purpose: register access link between the host controller and the display device
// Assumes: both ends on sys_clk_in
// Notes:   request held until ack, ack is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
interface osd_link_if (
  input wire logic sys_clk_in
);
  logic        req_valid;
  logic        req_write;
  logic [2:0]  req_reg;
  logic [7:0]  req_wdata;
  logic        ack;
  logic [15:0] rdata;

  modport device (
    input  req_valid,
    input  req_write,
    input  req_reg,
    input  req_wdata,
    output ack,
    output rdata
  );
  modport host (
    output req_valid,
    output req_write,
    output req_reg,
    output req_wdata,
    input  ack,
    input  rdata
  );
endinterface
`default_nettype wire

// ### core/osd_host_ctl.sv
// Purpose: host-side controller, turns AXI4-Lite commands into link accesses
// Assumes: software sequences the register writes, one link access at a time
// Notes:   command while busy is dropped, status bit shows busy
`timescale 1ns/100ps
`default_nettype none
module osd_host_ctl
  import osd_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  osd_link_if.host         link,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [3:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic [1:0]       s_axi_bresp_out,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [3:0]  s_axi_araddr_in,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out
);
  import osd_pkg::*;

  typedef struct packed {
    logic        aw_held;
    logic [3:0]  awaddr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        busy;
    logic        req_valid;
    logic        req_write;
    logic [2:0]  req_reg;
    logic [7:0]  req_wdata;
    logic [15:0] last_rdata;
  } host_state_t;

  host_state_t q;
  host_state_t d;

  ////////////////////////////////////////////////////////////////////////

  always_comb begin
    d = q;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      d.aw_held = 1'b1;
      d.awaddr  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      d.w_held = 1'b1;
      d.wdata  = s_axi_wdata_in;
      d.wstrb  = s_axi_wstrb_in;
    end
    if (q.bvalid && s_axi_bready_in) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready_in) begin
      d.rvalid = 1'b0;
    end

    // link completion; host drops the request the cycle after ack
    if (q.req_valid && link.ack) begin
      d.req_valid = 1'b0;
      d.busy      = 1'b0;
      if (!q.req_write) begin
        d.last_rdata = link.rdata;
      end
    end

    // both halves in: perform the write
    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      if (q.awaddr == AXI_CMD_OFS) begin
        // partial strobes would split a command, so all three low lanes needed
        if (!q.busy && (&q.wstrb[2:0])) begin
          d.busy      = 1'b1;
          d.req_valid = 1'b1;
          d.req_write = q.wdata[CMD_WRITE_BIT];
          d.req_reg   = q.wdata[CMD_REG_LO +: 3];
          d.req_wdata = q.wdata[CMD_DATA_LO +: 8];
        end
      end else if (q.awaddr != AXI_STAT_OFS && q.awaddr != AXI_RDATA_OFS) begin
        d.bresp = RESP_SLVERR;
      end
    end

    if (s_axi_arvalid_in && s_axi_arready_out) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      case (s_axi_araddr_in)
        AXI_CMD_OFS:   d.rdata = {15'h0, q.req_write, 5'h00, q.req_reg, q.req_wdata};
        AXI_STAT_OFS:  d.rdata = {31'h0, q.busy};
        AXI_RDATA_OFS: d.rdata = {16'h0000, q.last_rdata};
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  assign s_axi_awready_out = !q.aw_held && !q.bvalid;
  assign s_axi_wready_out  = !q.w_held && !q.bvalid;
  assign s_axi_bvalid_out  = q.bvalid;
  assign s_axi_bresp_out   = q.bresp;
  assign s_axi_arready_out = !q.rvalid;
  assign s_axi_rvalid_out  = q.rvalid;
  assign s_axi_rdata_out   = q.rdata;
  assign s_axi_rresp_out   = q.rresp;
  assign link.req_valid    = q.req_valid;
  assign link.req_write    = q.req_write;
  assign link.req_reg      = q.req_reg;
  assign link.req_wdata    = q.req_wdata;
endmodule
`default_nettype wire

// ### verification/osd_link_checker.sv
// Purpose: protocol and read-layout watch on the display-memory link
// Assumes: one clock, synchronous active-high reset
// Notes:   mode copy follows host writes; the width bit survives termination
`timescale 1ns/100ps
`default_nettype none
module osd_link_checker (
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [2:0]  req_reg,
  input wire logic [7:0]  req_wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata
);
  import osd_pkg::*;
  logic       rd_ack;
  logic [7:0] mode_q;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  assign rd_ack = ack && !req_write && req_reg == REG_DATA_OUT;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      mode_q <= MODE_RESET;
    end else if (ack && req_write && req_reg == REG_MODE) begin
      mode_q <= req_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_take_ack;
    req_valid && !ack |=> ack;
  endproperty
  a_take_ack: assert property (p_take_ack)
    else $error("request not answered next cycle");
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_cause;
    ack |-> $past(req_valid);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_release;
    ack |=> !req_valid;
  endproperty
  a_release: assert property (p_release)
    else $error("request not released after ack");
  property p_hold;
    req_valid && !ack |=> req_valid && $stable({req_write, req_reg, req_wdata});
  endproperty
  a_hold: assert property (p_hold)
    else $error("request changed before ack");
  property p_rdata_cause;
    $changed(rdata) |-> ack && !req_write;
  endproperty
  a_rdata_cause: assert property (p_rdata_cause)
    else $error("read data moved outside a read ack");
  property p_rd8;
    rd_ack && mode_q[MODE_WIDTH8_BIT] |-> rdata[15:8] == 8'h00;
  endproperty
  a_rd8: assert property (p_rd8)
    else $error("byte read returned a second byte");
  property p_rd16;
    rd_ack && !mode_q[MODE_WIDTH8_BIT] |-> rdata[7:5] == 3'h0 && rdata[1:0] == 2'h0;
  endproperty
  a_rd16: assert property (p_rd16)
    else $error("word read attribute outside read layout");
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: drives host controller over AXI4-Lite, checks display-memory accesses
// Assumes: controller polls busy; one link access at a time
// Notes:   fetch of location 0x123 is watched after it is written
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb_top;
  import osd_pkg::*;
  logic        sys_clk_in, rst_in, awvalid, wvalid, bready, arvalid, rready, armed;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, d, rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        overlay_on_out, fetch_valid_out, fetch_dropped_out;
  logic [8:0]  fetch_loc_out;
  logic [7:0]  fetch_char_out, fetch_attr_out;
  int          n_mismatch, samples_checked, n_drop, n_hit;
  logic [8:0]  locs [4] = '{9'h0fe, 9'h0ff, 9'h100, 9'h101};
  logic [15:0] exps [4] = '{16'h1108, 16'h2208, 16'h4408, 16'h0000};
  always #2.5 sys_clk_in = ~sys_clk_in;
  osd_link_if osd_link_if_i (.sys_clk_in(sys_clk_in));
  osd_host_ctl osd_host_ctl_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .link(osd_link_if_i),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp));
  osd_dispmem_dev osd_dispmem_dev_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .link(osd_link_if_i), .overlay_on_out(overlay_on_out), .fetch_valid_out(fetch_valid_out),
    .fetch_dropped_out(fetch_dropped_out), .fetch_loc_out(fetch_loc_out),
    .fetch_char_out(fetch_char_out), .fetch_attr_out(fetch_attr_out));
  osd_link_checker osd_link_checker_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .req_valid(osd_link_if_i.req_valid), .req_write(osd_link_if_i.req_write),
    .req_reg(osd_link_if_i.req_reg), .req_wdata(osd_link_if_i.req_wdata),
    .ack(osd_link_if_i.ack), .rdata(osd_link_if_i.rdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // handshakes judged at the falling edge, where the slave's outputs are settled
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
                        input logic [1:0] er);
    logic       aw_hs;
    logic       w_hs;
    logic       b_hs;
    logic [1:0] resp;
    b_hs = 1'b0;
    @(posedge sys_clk_in);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    bready <= 1'b1;
    while (!b_hs) begin
      @(negedge sys_clk_in);
      aw_hs = awvalid && (awready === 1'b1);
      w_hs = wvalid && (wready === 1'b1);
      b_hs = (bvalid === 1'b1);
      resp = bresp;
      @(posedge sys_clk_in);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    `CHK(resp, er)
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] v);
    logic       ar_hs;
    logic       r_hs;
    logic [1:0] resp;
    r_hs = 1'b0;
    @(posedge sys_clk_in);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!r_hs) begin
      @(negedge sys_clk_in);
      ar_hs = arvalid && (arready === 1'b1);
      r_hs = (rvalid === 1'b1);
      v = rdata;
      resp = rresp;
      @(posedge sys_clk_in);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    `CHK(resp, er)
  endtask
  // a command during busy is dropped, so every link access waits here
  task automatic idle();
    logic [31:0] v;
    v = 32'h1;
    while (v[0] !== 1'b0) axi_rd(AXI_STAT_OFS, RESP_OKAY, v);
  endtask
  task automatic lw(input logic [2:0] r, input logic [7:0] v);
    axi_wr(AXI_CMD_OFS, {15'h0, 1'b1, 5'h0, r, v}, 4'hf, RESP_OKAY);
    idle();
  endtask
  task automatic lr(input logic [2:0] r, input logic [15:0] exp);
    logic [31:0] v;
    axi_wr(AXI_CMD_OFS, {21'h0, r, 8'h00}, 4'hf, RESP_OKAY);
    idle();
    axi_rd(AXI_RDATA_OFS, RESP_OKAY, v);
    `CHK(v[15:0], exp)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // fetch pulses are one cycle wide, read them mid-cycle to avoid the launch-edge race
  always @(negedge sys_clk_in) begin
    if (fetch_dropped_out === 1'b1) n_drop++;
    if (armed && fetch_valid_out === 1'b1 && fetch_loc_out === 9'h123) begin
      n_hit++;
      `CHK({fetch_char_out, fetch_attr_out}, 16'h41a0)
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_mismatch++;
    close_out();
  end
  initial begin
    {sys_clk_in, awvalid, wvalid, bready, arvalid, rready, armed} = '0;
    {awaddr, araddr, wdata, d} = '0;
    wstrb = 4'hf;
    rst_in = 1'b1;
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    lw(REG_MODE, 8'h28);
    lw(REG_ADDR_HIGH, 8'h01);
    lw(REG_ADDR_LOW, 8'h23);
    lw(REG_DATA_IN, 8'h41);
    lr(REG_DATA_OUT, 16'h4114);
    armed = 1'b1;
    lw(REG_MODE, 8'h40);
    lw(REG_ADDR_HIGH, 8'h03);
    lr(REG_DATA_OUT, 16'h00a0);
    lw(REG_ADDR_LOW, 8'h50);
    lw(REG_DATA_IN, 8'h5a);
    lw(REG_ADDR_HIGH, 8'h01);
    lw(REG_DATA_IN, 8'h77);
    lr(REG_DATA_OUT, 16'h0077);
    lw(REG_MODE, 8'h00);
    lr(REG_DATA_OUT, 16'h7708);
    lw(REG_MODE, 8'h11);
    lw(REG_ADDR_HIGH, 8'h00);
    lw(REG_ADDR_LOW, 8'hfe);
    lw(REG_DATA_IN, 8'h11);
    lw(REG_DATA_IN, 8'h22);
    lw(REG_DATA_IN, 8'hff);
    lw(REG_DATA_IN, 8'h33);
    lw(REG_DATA_IN, 8'h44);
    for (int i = 0; i < 4; i++) begin
      lw(REG_ADDR_HIGH, {7'h0, locs[i][8]});
      lw(REG_ADDR_LOW, locs[i][7:0]);
      lr(REG_DATA_OUT, exps[i]);
    end
    lw(REG_DATA_IN, 8'hff);
    lr(REG_DATA_OUT, 16'hff08);
    // partial strobe must leave the overlay untouched
    axi_wr(AXI_CMD_OFS, {15'h0, 1'b1, 5'h0, REG_VIDEO_CTL, 8'h08}, 4'h8, RESP_OKAY);
    idle();
    `CHK(overlay_on_out, 1'b0)
    lw(REG_VIDEO_CTL, 8'h08);
    `CHK(overlay_on_out, 1'b1)
    lw(REG_VIDEO_CTL, 8'h04);
    `CHK(overlay_on_out, 1'b0)
    axi_wr(4'hc, 32'h0, 4'hf, RESP_SLVERR);
    axi_rd(4'hc, RESP_SLVERR, d);
    `CHK(d, 32'h0)
    lr(3'h7, 16'h0000);
    // growing gaps walk the access across six of the eight fetch-slot phases
    for (int i = 0; i < 8; i++) begin
      repeat (i) @(posedge sys_clk_in);
      lr(REG_DATA_OUT, 16'hff08);
    end
    `CHK(n_drop != 0, 1'b1)
    repeat (4200) @(posedge sys_clk_in);
    `CHK(n_hit != 0, 1'b1)
    close_out();
  end
endmodule
`default_nettype wire
